// >>> tmr_pkg.sv
// Shared constants and types of the two-channel timer
package tmr_pkg;

  // Widths of the register port and of the counting path
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int PRE_W = 7;
  localparam int PS_W = 3;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] OFS_STATUS_CTRL = 8'h20;
  localparam logic [7:0] OFS_CNT_HI = 8'h21;
  localparam logic [7:0] OFS_CNT_LO = 8'h22;
  localparam logic [7:0] OFS_MOD_HI = 8'h23;
  localparam logic [7:0] OFS_MOD_LO = 8'h24;
  localparam logic [7:0] OFS_CH0_CTRL = 8'h25;
  localparam logic [7:0] OFS_CH0_VAL_HI = 8'h26;
  localparam logic [7:0] OFS_CH0_VAL_LO = 8'h27;
  localparam logic [7:0] OFS_CH1_CTRL = 8'h28;
  localparam logic [7:0] OFS_CH1_VAL_HI = 8'h29;
  localparam logic [7:0] OFS_CH1_VAL_LO = 8'h2A;

  // Field positions of timer_status_control
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_OVF_IE = 6;
  localparam int BIT_STOP = 5;
  localparam int BIT_CNT_RST = 4;
  localparam int PS_LSB = 0;

  // Field positions of the channel status/control registers
  localparam int CH_BIT_FLAG = 7;
  localparam int CH_BIT_BUF = 5;

  // Reset values and special codes
  localparam logic RST_STOP = 1'b1;
  localparam logic [CNT_W-1:0] RST_MOD = 16'hFFFF;
  localparam logic [PS_W-1:0] RST_PS = 3'h0;
  localparam logic [PS_W-1:0] PS_NONE = 3'h7;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // Edge/level select codes
  localparam logic [1:0] ELS_PORT = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;

  // Channel control bits 6..0, in register order
  typedef struct packed {
    logic ie;
    logic buf_sel;
    logic mode_a;
    logic els_b;
    logic els_a;
    logic tov;
    logic max;
  } tmr_ch_ctrl_s;

  localparam tmr_ch_ctrl_s CH_CTRL_RST = '0;

  // Operating mode of a channel decoded from its control bits
  typedef enum logic [3:0] {
    MODE_PORT = 4'b0001,
    MODE_CAPTURE = 4'b0010,
    MODE_COMPARE = 4'b0100,
    MODE_BUF_COMPARE = 4'b1000
  } tmr_ch_mode_e;

endpackage

// >>> tmr_channel.sv
`timescale 1ns/1ps
// One capture/compare channel: control register, flag, value and pin
module tmr_channel #(
  parameter bit HAS_BUF = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [15:0] cnt_i,
  input wire logic tick_i,
  input wire logic ovf_i,
  input wire logic ctrl_wr_i,
  input wire logic ctrl_rd_i,
  input wire logic val_hi_wr_i,
  input wire logic val_lo_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic pin_i,
  output logic [7:0] ctrl_o,
  output logic [15:0] val_o,
  output logic irq_o,
  output logic pin_o,
  output logic pin_oe_n_o
);

  tmr_pkg::tmr_ch_ctrl_s ctrl_r;
  tmr_pkg::tmr_ch_mode_e mode;
  logic flag_r;
  logic arm_r;
  logic [15:0] val_r;
  logic [7:0] val_hi_r;
  logic cmp_inhibit_r;
  logic pin_prev_r;
  logic pin_r;
  logic oe_n_r;
  logic irq_r;
  logic edge_hit;
  logic cmp_hit;
  logic evt;

  // Mode decode from buffered, mode A and edge/level bits
  always_comb begin
    if ({ctrl_r.els_b, ctrl_r.els_a} == tmr_pkg::ELS_PORT) begin
      mode = tmr_pkg::MODE_PORT;
    end else if (ctrl_r.buf_sel) begin
      mode = tmr_pkg::MODE_BUF_COMPARE;
    end else if (ctrl_r.mode_a) begin
      mode = tmr_pkg::MODE_COMPARE;
    end else begin
      mode = tmr_pkg::MODE_CAPTURE;
    end
  end

  // Active edge and compare match detection
  always_comb begin
    unique case ({ctrl_r.els_b, ctrl_r.els_a})
      tmr_pkg::ELS_RISE: edge_hit = pin_i & ~pin_prev_r;
      tmr_pkg::ELS_FALL: edge_hit = ~pin_i & pin_prev_r;
      tmr_pkg::ELS_BOTH: edge_hit = pin_i ^ pin_prev_r;
      default: edge_hit = 1'b0;
    endcase
    cmp_hit = tick_i & (cnt_i == val_r) & ~cmp_inhibit_r;
    // Capture flags on pin edges, both compare modes on a match
    unique case (mode)
      tmr_pkg::MODE_CAPTURE: evt = edge_hit;
      tmr_pkg::MODE_PORT: evt = 1'b0;
      default: evt = cmp_hit;
    endcase
  end

  // Pin history for edge detection
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_i;
    end
  end

  // Control bits; bit 5 exists only where buffering is offered
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= tmr_pkg::CH_CTRL_RST;
    end else if (ctrl_wr_i) begin
      ctrl_r <= tmr_ch_ctrl_s_of(wdata_i);
    end
  end

  function automatic tmr_pkg::tmr_ch_ctrl_s tmr_ch_ctrl_s_of(
    input logic [7:0] d);
    tmr_pkg::tmr_ch_ctrl_s c;
    c = d[6:0];
    c.buf_sel = HAS_BUF ? d[tmr_pkg::CH_BIT_BUF] : 1'b0;
    return c;
  endfunction

  // Flag: event wins over a clear, clear needs a prior read of 1
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      if (evt) begin
        flag_r <= 1'b1;
      end else if (ctrl_wr_i && !wdata_i[tmr_pkg::CH_BIT_FLAG] && arm_r) begin
        flag_r <= 1'b0;
      end
      if (evt || ctrl_wr_i) begin
        arm_r <= 1'b0;
      end else if (ctrl_rd_i && flag_r) begin
        arm_r <= 1'b1;
      end
    end
  end

  // Value: capture store or two-byte software write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      val_r <= '0;
      val_hi_r <= tmr_pkg::DATA_ZERO;
      cmp_inhibit_r <= 1'b0;
    end else begin
      if (val_hi_wr_i) begin
        val_hi_r <= wdata_i;
        cmp_inhibit_r <= 1'b1; // Half-written value must not match
      end else if (val_lo_wr_i) begin
        val_r <= {val_hi_r, wdata_i};
        cmp_inhibit_r <= 1'b0;
      end else if (evt && mode == tmr_pkg::MODE_CAPTURE) begin
        val_r <= cnt_i;
      end
    end
  end

  // Pin drive; overflow toggle beats a same-cycle compare
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else begin
      unique case (mode)
        tmr_pkg::MODE_PORT: begin
          pin_r <= ~ctrl_r.mode_a;
          oe_n_r <= 1'b1;
        end
        tmr_pkg::MODE_CAPTURE: begin
          oe_n_r <= 1'b1;
        end
        default: begin
          oe_n_r <= 1'b0;
          if (ovf_i && ctrl_r.tov) begin
            pin_r <= ~pin_r;
          end else if (cmp_hit) begin
            unique case ({ctrl_r.els_b, ctrl_r.els_a})
              tmr_pkg::ELS_RISE: pin_r <= ~pin_r;
              tmr_pkg::ELS_FALL: pin_r <= 1'b0;
              default: pin_r <= 1'b1;
            endcase
          end
        end
      endcase
    end
  end

  // Interrupt request follows flag and enable
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r & ctrl_r.ie;
    end
  end

  assign ctrl_o = {flag_r, ctrl_r};
  assign val_o = val_r;
  assign irq_o = irq_r;
  assign pin_o = pin_r;
  assign pin_oe_n_o = oe_n_r;

endmodule // tmr_channel

// >>> tmr_timer.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module tmr_timer (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic ovf_irq_o,
  output logic [1:0] ch_irq_o,
  input wire logic [1:0] ch_pin_i,
  output logic [1:0] ch_pin_o,
  output logic [1:0] ch_pin_oe_n_o
);

  // Address decode
  logic sel_status;
  logic sel_cnt_hi;
  logic sel_cnt_lo;
  logic sel_mod_hi;
  logic sel_mod_lo;
  logic sel_ch0_ctrl;
  logic sel_ch0_hi;
  logic sel_ch0_lo;
  logic sel_ch1_ctrl;
  logic sel_ch1_hi;
  logic sel_ch1_lo;

  // Status/control state
  logic ovf_flag_r;
  logic ovf_arm_r;
  logic ovf_ie_r;
  logic stop_r;
  logic [2:0] ps_r;

  // Counting path
  logic [6:0] pre_r;
  logic [6:0] pre_mask;
  logic [15:0] cnt_r;
  logic [15:0] mod_r;
  logic mod_inhibit_r;
  logic cnt_rst;
  logic tick;
  logic tick_en;
  logic at_mod;
  logic rollover;
  logic ovf_evt;

  // Counter readback latch
  logic [7:0] lo_latch_r;
  logic latched_r;

  // Read data and requests
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic ovf_irq_r;

  // Channel connections
  logic [7:0] ch0_ctrl;
  logic [7:0] ch1_ctrl;
  logic [15:0] ch0_val;
  logic [15:0] ch1_val;

  // Register selects
  always_comb begin
    sel_status = addr_i == tmr_pkg::OFS_STATUS_CTRL;
    sel_cnt_hi = addr_i == tmr_pkg::OFS_CNT_HI;
    sel_cnt_lo = addr_i == tmr_pkg::OFS_CNT_LO;
    sel_mod_hi = addr_i == tmr_pkg::OFS_MOD_HI;
    sel_mod_lo = addr_i == tmr_pkg::OFS_MOD_LO;
    sel_ch0_ctrl = addr_i == tmr_pkg::OFS_CH0_CTRL;
    sel_ch0_hi = addr_i == tmr_pkg::OFS_CH0_VAL_HI;
    sel_ch0_lo = addr_i == tmr_pkg::OFS_CH0_VAL_LO;
    sel_ch1_ctrl = addr_i == tmr_pkg::OFS_CH1_CTRL;
    sel_ch1_hi = addr_i == tmr_pkg::OFS_CH1_VAL_HI;
    sel_ch1_lo = addr_i == tmr_pkg::OFS_CH1_VAL_LO;
  end

  // The counter-reset bit is a pulse, never stored
  assign cnt_rst = wr_i & sel_status &
                   wdata_i[tmr_pkg::BIT_CNT_RST];

  // Tick when every prescaler bit below the selected tap is one
  always_comb begin
    pre_mask = (tmr_pkg::PRE_ONE << ps_r) - tmr_pkg::PRE_ONE;
    tick = (ps_r != tmr_pkg::PS_NONE) &&
           ((pre_r & pre_mask) == pre_mask);
    tick_en = tick & ~stop_r & ~cnt_rst;
    at_mod = cnt_r == mod_r;
    rollover = tick_en & at_mod;
    ovf_evt = rollover & ~mod_inhibit_r;
  end

  // Status/control fields other than the flag
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_ie_r <= 1'b0;
      stop_r <= tmr_pkg::RST_STOP;
      ps_r <= tmr_pkg::RST_PS;
    end else if (wr_i && sel_status) begin
      ovf_ie_r <= wdata_i[tmr_pkg::BIT_OVF_IE];
      stop_r <= wdata_i[tmr_pkg::BIT_STOP];
      ps_r <= wdata_i[tmr_pkg::PS_LSB +: tmr_pkg::PS_W];
    end
  end

  // Overflow flag: set beats clear, a 1 written is ignored
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_r <= 1'b1;
    end else if (wr_i && sel_status && ovf_arm_r &&
                 !wdata_i[tmr_pkg::BIT_OVF_FLAG]) begin
      ovf_flag_r <= 1'b0;
    end
  end

  // Clear arming: a read seeing 1 arms, an overflow or any status/control write disarms
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_arm_r <= 1'b0;
    end else if (ovf_evt || (wr_i && sel_status)) begin
      ovf_arm_r <= 1'b0;
    end else if (rd_i && sel_status && ovf_flag_r) begin
      ovf_arm_r <= 1'b1;
    end
  end

  // Prescaler runs only while the counter is not stopped
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_r <= '0;
    end else if (cnt_rst) begin
      pre_r <= '0;
    end else if (!stop_r) begin
      pre_r <= pre_r + tmr_pkg::PRE_ONE;
    end
  end

  // Counter: clear, roll over at modulo, or count up
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= '0;
    end else if (cnt_rst) begin
      cnt_r <= '0;
    end else if (rollover) begin
      cnt_r <= '0;
    end else if (tick_en) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Modulo bytes; a high write holds off the overflow flag until the low write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mod_r <= tmr_pkg::RST_MOD;
      mod_inhibit_r <= 1'b0;
    end else if (wr_i && sel_mod_hi) begin
      mod_r[15:8] <= wdata_i;
      mod_inhibit_r <= 1'b1;
    end else if (wr_i && sel_mod_lo) begin
      mod_r[7:0] <= wdata_i;
      mod_inhibit_r <= 1'b0;
    end
  end

  // Low-byte latch keeps a coherent 16-bit readback
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_latch_r <= tmr_pkg::DATA_ZERO;
      latched_r <= 1'b0;
    end else if (rd_i && sel_cnt_lo) begin
      latched_r <= 1'b0;
    end else if (rd_i && sel_cnt_hi && !latched_r) begin
      lo_latch_r <= cnt_r[7:0];
      latched_r <= 1'b1;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_nxt = tmr_pkg::DATA_ZERO;
    if (sel_status) begin
      rdata_nxt[tmr_pkg::BIT_OVF_FLAG] = ovf_flag_r;
      rdata_nxt[tmr_pkg::BIT_OVF_IE] = ovf_ie_r;
      rdata_nxt[tmr_pkg::BIT_STOP] = stop_r;
      rdata_nxt[tmr_pkg::PS_LSB +: tmr_pkg::PS_W] = ps_r;
    end else if (sel_cnt_hi) begin
      rdata_nxt = cnt_r[15:8];
    end else if (sel_cnt_lo) begin
      rdata_nxt = latched_r ? lo_latch_r : cnt_r[7:0];
    end else if (sel_mod_hi) begin
      rdata_nxt = mod_r[15:8];
    end else if (sel_mod_lo) begin
      rdata_nxt = mod_r[7:0];
    end else if (sel_ch0_ctrl) begin
      rdata_nxt = ch0_ctrl;
    end else if (sel_ch0_hi) begin
      rdata_nxt = ch0_val[15:8];
    end else if (sel_ch0_lo) begin
      rdata_nxt = ch0_val[7:0];
    end else if (sel_ch1_ctrl) begin
      rdata_nxt = ch1_ctrl;
    end else if (sel_ch1_hi) begin
      rdata_nxt = ch1_val[15:8];
    end else if (sel_ch1_lo) begin
      rdata_nxt = ch1_val[7:0];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= tmr_pkg::DATA_ZERO;
    end else if (rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= tmr_pkg::DATA_ZERO;
    end
  end

  // Overflow request, registered so the port comes from a flip-flop
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_irq_r <= 1'b0;
    end else begin
      ovf_irq_r <= ovf_flag_r & ovf_ie_r;
    end
  end

  // Channel 0 carries the buffered-mode bit
  tmr_channel #(
    .HAS_BUF(1'b1)
  ) u_ch0 (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .cnt_i(cnt_r),
    .tick_i(tick_en),
    .ovf_i(rollover),
    .ctrl_wr_i(wr_i & sel_ch0_ctrl),
    .ctrl_rd_i(rd_i & sel_ch0_ctrl),
    .val_hi_wr_i(wr_i & sel_ch0_hi),
    .val_lo_wr_i(wr_i & sel_ch0_lo),
    .wdata_i(wdata_i),
    .pin_i(ch_pin_i[0]),
    .ctrl_o(ch0_ctrl),
    .val_o(ch0_val),
    .irq_o(ch_irq_o[0]),
    .pin_o(ch_pin_o[0]),
    .pin_oe_n_o(ch_pin_oe_n_o[0])
  );

  // Channel 1 has no buffered-mode bit
  tmr_channel #(
    .HAS_BUF(1'b0)
  ) u_ch1 (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .cnt_i(cnt_r),
    .tick_i(tick_en),
    .ovf_i(rollover),
    .ctrl_wr_i(wr_i & sel_ch1_ctrl),
    .ctrl_rd_i(rd_i & sel_ch1_ctrl),
    .val_hi_wr_i(wr_i & sel_ch1_hi),
    .val_lo_wr_i(wr_i & sel_ch1_lo),
    .wdata_i(wdata_i),
    .pin_i(ch_pin_i[1]),
    .ctrl_o(ch1_ctrl),
    .val_o(ch1_val),
    .irq_o(ch_irq_o[1]),
    .pin_o(ch_pin_o[1]),
    .pin_oe_n_o(ch_pin_oe_n_o[1])
  );

  assign rdata_o = rdata_r;
  assign ovf_irq_o = ovf_irq_r;

endmodule // tmr_timer

// >>> tmr_timer_monitor.sv
`timescale 1ns/1ps
// Watches the register port and request outputs of the timer
module tmr_timer_monitor (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic ovf_irq_o,
  input wire logic [1:0] ch_irq_o,
  input wire logic [1:0] ch_pin_i,
  input wire logic [1:0] ch_pin_o,
  input wire logic [1:0] ch_pin_oe_n_o
);
  logic ie_r;
  logic stop_r;
  logic [2:0] ps_r;
  logic [6:0] ch0_r;
  logic [6:0] ch1_r;
  logic [1:0] ch_ie;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // Shadow of the status fields; only the bus can move them
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ie_r <= 1'b0;
      stop_r <= 1'b1;
      ps_r <= 3'h0;
    end else if (wr_i && addr_i == tmr_pkg::OFS_STATUS_CTRL) begin
      ie_r <= wdata_i[6];
      stop_r <= wdata_i[5];
      ps_r <= wdata_i[2:0];
    end
  end

  // Shadow of channel control bits 6..0; channel 1 has no bit 5
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ch0_r <= 7'h00;
      ch1_r <= 7'h00;
    end else if (wr_i && addr_i == tmr_pkg::OFS_CH0_CTRL) begin
      ch0_r <= wdata_i[6:0];
    end else if (wr_i && addr_i == tmr_pkg::OFS_CH1_CTRL) begin
      ch1_r <= {wdata_i[6], 1'b0, wdata_i[4:0]};
    end
  end

  assign ch_ie = {ch1_r[6], ch0_r[6]};

  // Read data only in the slot after a read strobe
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  property p_status_read;
    $past(rd_i && addr_i == tmr_pkg::OFS_STATUS_CTRL) |->
      rdata_o[6:0] == {$past(ie_r), $past(stop_r), 2'b00, $past(ps_r)};
  endproperty
  property p_ch0_read;
    $past(rd_i && addr_i == tmr_pkg::OFS_CH0_CTRL) |->
      rdata_o[6:0] == $past(ch0_r);
  endproperty
  property p_ch1_read;
    $past(rd_i && addr_i == tmr_pkg::OFS_CH1_CTRL) |->
      rdata_o[6:0] == $past(ch1_r);
  endproperty
  // Requests lag flag and enable by one cycle
  property p_ovf_gate;
    ovf_irq_o |-> $past(ie_r);
  endproperty
  property p_ch_gate;
    (ch_irq_o & ~$past(ch_ie)) == 2'b00;
  endproperty
  // A request can only drop after a write to its own register
  property p_ovf_fall;
    $fell(ovf_irq_o) |->
      $past(wr_i && addr_i == tmr_pkg::OFS_STATUS_CTRL, 2);
  endproperty
  property p_ch_fall;
    $fell(ch_irq_o[0]) |-> $past(wr_i && addr_i == tmr_pkg::OFS_CH0_CTRL, 2);
  endproperty

  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its slot");
  a_status_read: assert property (p_status_read)
    else $error("status readback differs from written fields");
  a_ch0_read: assert property (p_ch0_read)
    else $error("channel 0 control readback wrong");
  a_ch1_read: assert property (p_ch1_read)
    else $error("channel 1 control readback wrong");
  a_ovf_gate: assert property (p_ovf_gate)
    else $error("overflow request without enable");
  a_ch_gate: assert property (p_ch_gate)
    else $error("channel request without enable");
  a_ovf_fall: assert property (p_ovf_fall)
    else $error("overflow request dropped without a write");
  a_ch_fall: assert property (p_ch_fall)
    else $error("channel request dropped without a write");

  c_ovf: cover property ($rose(ovf_irq_o));
  c_ch0: cover property ($rose(ch_irq_o[0]));
  c_ch1: cover property ($rose(ch_irq_o[1]));
endmodule // tmr_timer_monitor

bind tmr_timer tmr_timer_monitor u_mon (
  .clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .ovf_irq_o(ovf_irq_o),
  .ch_irq_o(ch_irq_o),
  .ch_pin_i(ch_pin_i),
  .ch_pin_o(ch_pin_o),
  .ch_pin_oe_n_o(ch_pin_oe_n_o)
);

// >>> tmr_timer_tb.sv
`timescale 1ns/1ps
`define TMR_CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tmr_timer_tb;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] ch_pin_i = 2'b00;
  logic [7:0] rdata_o;
  logic ovf_irq_o;
  logic [1:0] ch_irq_o;
  logic [1:0] ch_pin_o;
  logic [1:0] ch_pin_oe_n_o;
  int checks = 0;
  int miscompares = 0;

  // Free-running 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;

  tmr_timer dut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .ovf_irq_o(ovf_irq_o),
    .ch_irq_o(ch_irq_o),
    .ch_pin_i(ch_pin_i),
    .ch_pin_o(ch_pin_o),
    .ch_pin_oe_n_o(ch_pin_oe_n_o)
  );

  // Bus write: sampled at the second edge, which is where the task ends
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // Bus read with compare; data are taken just after the sampling edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    `TMR_CHK(rdata_o, e);
  endtask

  // Let a number of edges pass and step off the edge
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic t_reset_values();
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'h20);
    rd_chk(tmr_pkg::OFS_CNT_HI, 8'h00);
    rd_chk(tmr_pkg::OFS_CNT_LO, 8'h00);
    rd_chk(tmr_pkg::OFS_MOD_HI, 8'hFF);
    rd_chk(tmr_pkg::OFS_MOD_LO, 8'hFF);
    rd_chk(tmr_pkg::OFS_CH0_CTRL, 8'h00);
    rd_chk(tmr_pkg::OFS_CH1_CTRL, 8'h00);
    wr(8'h40, 8'hFF);
    rd_chk(8'h40, 8'h00);
    `TMR_CHK(ch_pin_oe_n_o, 2'b11);
    $display("test reset_values done");
  endtask

  // Divide by 64 keeps the count still for 64 cycles, clear of edges
  task automatic t_latch();
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h16);
    repeat (328) @(posedge clk_sys_i);
    rd_chk(tmr_pkg::OFS_CNT_HI, 8'h00);
    repeat (68) @(posedge clk_sys_i);
    wr(tmr_pkg::OFS_CNT_HI, 8'hFF);
    rd_chk(tmr_pkg::OFS_CNT_HI, 8'h00);
    rd_chk(tmr_pkg::OFS_CNT_LO, 8'h05);
    rd_chk(tmr_pkg::OFS_CNT_HI, 8'h00);
    rd_chk(tmr_pkg::OFS_CNT_LO, 8'h06);
    $display("test latch done");
  endtask

  // Run 200 cycles per prescale code and read the frozen count
  task automatic t_prescale();
    logic [2:0] ps;
    logic [15:0] exp;
    for (int i = 0; i < 8; i++) begin
      ps = 3'(i);
      exp = (ps == 3'h7) ? 16'h0000 : 16'(200 >> i);
      wr(tmr_pkg::OFS_STATUS_CTRL, 8'h30);
      rd_chk(tmr_pkg::OFS_CNT_LO, 8'h00);
      rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'h20);
      wr(tmr_pkg::OFS_STATUS_CTRL, {5'b00010, ps});
      repeat (198) @(posedge clk_sys_i);
      wr(tmr_pkg::OFS_STATUS_CTRL, {5'b00100, ps});
      pause(20);
      rd_chk(tmr_pkg::OFS_CNT_HI, exp[15:8]);
      rd_chk(tmr_pkg::OFS_CNT_LO, exp[7:0]);
    end
    $display("test prescale done");
  endtask

  task automatic t_overflow();
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h30);
    wr(tmr_pkg::OFS_MOD_HI, 8'h00);
    wr(tmr_pkg::OFS_MOD_LO, 8'h09);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h50);
    repeat (31) @(posedge clk_sys_i);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h60);
    rd_chk(tmr_pkg::OFS_CNT_LO, 8'h03);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'hE0);
    `TMR_CHK(ovf_irq_o, 1'b1);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'hE0);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'hE0);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h60);
    pause(2);
    `TMR_CHK(ovf_irq_o, 1'b0);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'h60);
    // An overflow between the arming read and the clearing write must win
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h50);
    pause(12);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'hC0);
    pause(6);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h40);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'hC0);
    `TMR_CHK(ovf_irq_o, 1'b1);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h00);
    pause(2);
    `TMR_CHK(ovf_irq_o, 1'b0);
    // Modulo high alone holds the flag off until the low byte lands
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h30);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'h20);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h20);
    wr(tmr_pkg::OFS_MOD_HI, 8'h00);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h10);
    pause(30);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'h00);
    wr(tmr_pkg::OFS_MOD_LO, 8'h09);
    pause(12);
    rd_chk(tmr_pkg::OFS_STATUS_CTRL, 8'h80);
    $display("test overflow done");
  endtask

  task automatic t_channels();
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h30);
    wr(tmr_pkg::OFS_CH0_CTRL, 8'hFF);
    rd_chk(tmr_pkg::OFS_CH0_CTRL, 8'h7F);
    wr(tmr_pkg::OFS_CH1_CTRL, 8'hFF);
    rd_chk(tmr_pkg::OFS_CH1_CTRL, 8'h5F);
    // Ch 0 toggles on compare at 5; ch 1 matches at the modulo value 9
    wr(tmr_pkg::OFS_CH0_VAL_HI, 8'h00);
    wr(tmr_pkg::OFS_CH0_VAL_LO, 8'h05);
    wr(tmr_pkg::OFS_CH1_VAL_HI, 8'h00);
    wr(tmr_pkg::OFS_CH1_VAL_LO, 8'h09);
    wr(tmr_pkg::OFS_CH0_CTRL, 8'h54);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h10);
    pause(12);
    wr(tmr_pkg::OFS_STATUS_CTRL, 8'h20);
    rd_chk(tmr_pkg::OFS_CH0_CTRL, 8'hD4);
    `TMR_CHK(ch_irq_o[0], 1'b1);
    `TMR_CHK(ch_pin_oe_n_o[0], 1'b0);
    `TMR_CHK(ch_pin_o, 2'b00);
    wr(tmr_pkg::OFS_CH0_CTRL, 8'h54);
    pause(2);
    `TMR_CHK(ch_irq_o[0], 1'b0);
    rd_chk(tmr_pkg::OFS_CH0_CTRL, 8'h54);
    // Read the compare flag as 1 first, so the next write clears it and only the capture can set it again
    rd_chk(tmr_pkg::OFS_CH1_CTRL, 8'hDF);
    // Rising-edge capture on channel 1, then a falling edge is ignored
    wr(tmr_pkg::OFS_CH1_CTRL, 8'h44);
    @(posedge clk_sys_i);
    ch_pin_i <= 2'b10;
    pause(3);
    rd_chk(tmr_pkg::OFS_CH1_CTRL, 8'hC4);
    `TMR_CHK(ch_irq_o[1], 1'b1);
    wr(tmr_pkg::OFS_CH1_CTRL, 8'h44);
    @(posedge clk_sys_i);
    ch_pin_i <= 2'b00;
    pause(3);
    rd_chk(tmr_pkg::OFS_CH1_CTRL, 8'h44);
    `TMR_CHK(ch_irq_o[1], 1'b0);
    $display("test channels done");
  endtask

  // Cuts a hang short well past the expected run of a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_reset_values();
    t_latch();
    t_prescale();
    t_overflow();
    t_channels();
    conclude();
  end
endmodule // tmr_timer_tb
